// >>> design/ops_pkg.sv
package ops_pkg;
   // ==========================================
   // register byte addresses
   localparam logic [4:0] ADR_MODE  = 5'h00;
   localparam logic [4:0] ADR_CAPC  = 5'h04;
   localparam logic [4:0] ADR_OUTC  = 5'h08;
   localparam logic [4:0] ADR_EDGE  = 5'h0C;
   localparam logic [4:0] ADR_COUNT = 5'h10;
   localparam logic [4:0] ADR_CCF   = 5'h14;
   localparam logic [4:0] ADR_CCS   = 5'h18;
   // ==========================================
   // field positions
   localparam int MODE_OVF = 0;
   localparam int MODE_OP  = 2;
   localparam int CAPC_C1  = 0;
   localparam int CAPC_OPP = 1;
   localparam int CAPC_C2  = 2;
   localparam int OUT_EN   = 0;
   localparam int OUT_INV1 = 1;
   localparam int OUT_INV2 = 4;
   localparam int OUT_OSE  = 5;
   localparam int OUT_OST  = 6;
   // ==========================================
   // encodings and reset values
   localparam logic [1:0] OP_STOP   = 2'h0;
   localparam logic [1:0] OP_FREE   = 2'h1;
   localparam logic [1:0] OP_EDGE   = 2'h2;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [7:0] RST_REG8  = 8'h00;
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam int CNT_WIDTH = 16;
   // ==========================================
   // types
   typedef enum {OS_IDLE, OS_WAIT, OS_PULSE} ops_os_t;
   typedef struct packed {
      logic trig_in_first;
      logic trig_in_second;
   } ops_trig_t;
   typedef struct packed {
      logic match_irq_first;
      logic match_irq_second;
   } ops_irq_t;
endpackage : ops_pkg

// >>> design/ops_timer.sv
`timescale 1ns/1ps
module ops_timer #(
   parameter int CNT_W = ops_pkg::CNT_WIDTH
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // avalon-mm slave
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // pins
   input  wire ops_pkg::ops_trig_t trig,
   output logic                   timer_out_pin,
   output ops_pkg::ops_irq_t      irq
);
   import ops_pkg::*;

   // the bus lanes carry at most sixteen counter bits
   generate
      if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
         $error("CNT_W must lie in 2..16");
      end
   endgenerate

   // ==========================================
   // helpers
   function automatic logic valid_edge(input logic [1:0] sel, input logic p, input logic c);
      case (sel)
         EDGE_FALL: valid_edge = p & ~c;
         EDGE_RISE: valid_edge = ~p & c;
         EDGE_BOTH: valid_edge = p ^ c;
         default:   valid_edge = 1'b0;
      endcase
   endfunction : valid_edge

   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
      wr16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : wr16

   // ==========================================
   // state
   logic [7:0]       mode_control_reg, capcmp_control_reg, output_control_reg, edge_reg;
   logic [7:0]       next_mode, next_capc, next_outc, next_edge;
   logic [CNT_W-1:0] count_reg, capcmp_first, capcmp_second;
   logic [CNT_W-1:0] next_count, next_ccf, next_ccs;
   ops_trig_t        sync1, sync2, sync3;
   logic             bus_ack, next_ack;
   logic [31:0]      next_rdata;
   logic             soft_trig, next_soft;
   logic             out_lvl, next_lvl;
   ops_os_t          os_state, next_os;
   logic             cap1_q, cap2_q, next_cap1_q, next_cap2_q;
   ops_irq_t         next_irq;

   // ==========================================
   // decode
   logic [1:0]       op;
   logic             running, os_en, valid1, opp1, valid2, os_trig, clr;
   logic             m1, m2, cap1, cap2, acc, wr_ok, ovf_evt;
   logic [15:0]      cnt16, ccf16, ccs16;

   assign op      = mode_control_reg[MODE_OP +: 2];
   assign running = (op != OP_STOP);
   assign os_en   = output_control_reg[OUT_OSE] && (op == OP_FREE || op == OP_EDGE);
   assign valid1  = valid_edge(edge_reg[1:0], sync3.trig_in_first, sync2.trig_in_first);
   // xor swaps rise and fall; both-edge select turns into an unused code
   assign opp1    = valid_edge(edge_reg[1:0] ^ 2'h1, sync3.trig_in_first, sync2.trig_in_first);
   assign valid2  = valid_edge(edge_reg[3:2], sync3.trig_in_second, sync2.trig_in_second);
   assign os_trig = os_en && (soft_trig || valid1);
   assign clr     = running && (os_trig || (op == OP_EDGE && valid1));
   assign m1      = running && !capcmp_control_reg[CAPC_C1] && count_reg == capcmp_first;
   assign m2      = running && !capcmp_control_reg[CAPC_C2] && count_reg == capcmp_second;
   assign cap1    = running && capcmp_control_reg[CAPC_C1]
                    && (capcmp_control_reg[CAPC_OPP] ? opp1 : valid2);
   assign cap2    = running && capcmp_control_reg[CAPC_C2] && valid1;
   assign ovf_evt = running && !clr && (&count_reg);
   assign acc     = (avs_read || avs_write) && !bus_ack;
   assign wr_ok   = avs_write && bus_ack;
   assign cnt16   = 16'(count_reg);
   assign ccf16   = 16'(capcmp_first);
   assign ccs16   = 16'(capcmp_second);

   // every access costs exactly one wait state; the read mux is registered
   // so that the bus never sees a half-settled count on its data lanes
   // trade-off: two clocks per access instead of one
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign timer_out_pin   = output_control_reg[OUT_EN] & out_lvl;

   // ==========================================
   // next values
   always_comb begin
      next_ack    = acc;
      next_rdata  = avs_readdata;
      next_mode   = mode_control_reg;
      next_capc   = capcmp_control_reg;
      next_outc   = output_control_reg;
      next_edge   = edge_reg;
      next_ccf    = capcmp_first;
      next_ccs    = capcmp_second;
      next_soft   = 1'b0;
      next_count  = count_reg;
      next_lvl    = out_lvl;
      next_os     = os_state;
      next_cap1_q = cap1 && !capcmp_control_reg[CAPC_OPP];
      next_cap2_q = cap2;
      // captures are stored now, their irq (none for an opposite-edge capture) follows one clock later
      next_irq.match_irq_first  = m1 || cap1_q;
      next_irq.match_irq_second = m2 || cap2_q;

      // read mux is sampled while waitrequest is high, shown at the ack clock
      if (acc && avs_read) begin
         case (avs_address)
            ADR_MODE:  next_rdata = {24'h000000, mode_control_reg};
            ADR_CAPC:  next_rdata = {24'h000000, capcmp_control_reg};
            ADR_OUTC:  next_rdata = {24'h000000, output_control_reg};
            ADR_EDGE:  next_rdata = {24'h000000, edge_reg};
            ADR_COUNT: next_rdata = {16'h0000, cnt16};
            ADR_CCF:   next_rdata = {16'h0000, ccf16};
            ADR_CCS:   next_rdata = {16'h0000, ccs16};
            default:   next_rdata = 32'h00000000;
         endcase
      end

      if (wr_ok && avs_byteenable[0]) begin
         case (avs_address)
            ADR_MODE: next_mode = {avs_writedata[7:1], mode_control_reg[MODE_OVF] & avs_writedata[0]};
            ADR_CAPC: next_capc = avs_writedata[7:0];
            ADR_OUTC: begin
               next_outc          = avs_writedata[7:0];
               next_outc[OUT_OST] = 1'b0;
               next_soft          = avs_writedata[OUT_OST];
            end
            ADR_EDGE: next_edge = avs_writedata[7:0];
            default: ;
         endcase
      end
      if (wr_ok && avs_address == ADR_CCF)
         next_ccf = CNT_W'(wr16(ccf16, avs_writedata, avs_byteenable));
      if (wr_ok && avs_address == ADR_CCS)
         next_ccs = CNT_W'(wr16(ccs16, avs_writedata, avs_byteenable));

      // a late overflow beats a software clear in the same clock
      if (ovf_evt)
         next_mode[MODE_OVF] = 1'b1;

      // captures beat a software write to the same register
      if (cap1)
         next_ccf = count_reg;
      if (cap2)
         next_ccs = count_reg;

      // stopping clears the count, so a restart always begins from zero
      // limitation: a stopped counter cannot be resumed where it left off
      if (!running)
         next_count = '0;
      else if (clr)
         next_count = '0;
      else
         next_count = count_reg + 1'b1;

      // in one-shot use the match edges own the level; the invert enables
      // are ignored so a stray enable bit cannot add a third edge per pulse
      // a second match without a first one leaves the pin low
      if (os_en) begin
         case (os_state)
            OS_IDLE: ;
            OS_WAIT: begin
               if (m1) begin
                  next_lvl = ~out_lvl;
                  next_os  = OS_PULSE;
               end
            end
            OS_PULSE: begin
               if (m2) begin
                  next_lvl = ~out_lvl;
                  next_os  = OS_IDLE;
               end
            end
            default: next_os = OS_IDLE;
         endcase
         if (os_trig) begin
            // a retrigger mid-pulse restarts from the inactive level
            next_lvl = 1'b0;
            next_os  = OS_WAIT;
         end
      end else begin
         next_os  = OS_IDLE;
         next_lvl = out_lvl ^ (m1 & output_control_reg[OUT_INV1]) ^ (m2 & output_control_reg[OUT_INV2]);
      end
   end

   // ==========================================
   // registers
   // sync1 and sync2 form the synchroniser; sync3 only keeps the previous
   // settled level for edge detection, so edges are seen two clocks late
   // pins must idle low at reset or a false edge follows release
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync1              <= '0;
         sync2              <= '0;
         sync3              <= '0;
         bus_ack            <= 1'b0;
         avs_readdata       <= 32'h00000000;
         mode_control_reg   <= RST_REG8;
         capcmp_control_reg <= RST_REG8;
         output_control_reg <= RST_REG8;
         edge_reg           <= RST_REG8;
         capcmp_first       <= '0;
         capcmp_second      <= '0;
         count_reg          <= '0;
         soft_trig          <= 1'b0;
         out_lvl            <= 1'b0;
         os_state           <= OS_IDLE;
         cap1_q             <= 1'b0;
         cap2_q             <= 1'b0;
         irq                <= '0;
      end else begin
         sync1              <= trig;
         sync2              <= sync1;
         sync3              <= sync2;
         bus_ack            <= next_ack;
         avs_readdata       <= next_rdata;
         mode_control_reg   <= next_mode;
         capcmp_control_reg <= next_capc;
         output_control_reg <= next_outc;
         edge_reg           <= next_edge;
         capcmp_first       <= next_ccf;
         capcmp_second      <= next_ccs;
         count_reg          <= next_count;
         soft_trig          <= next_soft;
         out_lvl            <= next_lvl;
         os_state           <= next_os;
         cap1_q             <= next_cap1_q;
         cap2_q             <= next_cap2_q;
         irq                <= next_irq;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_cap_then_irq;
      capcmp_second == $past(count_reg) ##1 irq.match_irq_second;
   endsequence

   sequence s_pulse_rise;
      os_state == OS_PULSE && out_lvl && irq.match_irq_first;
   endsequence

   a_stop_holds_zero: assert property (!running |=> count_reg == '0)
      else $error("counter not held while stopped");
   a_ovf_sets_flag: assert property (ovf_evt |=> mode_control_reg[MODE_OVF])
      else $error("overflow flag not set");
   a_read_no_disturb: assert property ((acc && avs_read && avs_address == ADR_COUNT && running && !clr)
      |=> count_reg == $past(count_reg) + 1'b1)
      else $error("counter read disturbed count");
   a_trig_restarts: assert property (clr |=> count_reg == '0)
      else $error("trigger did not clear counter");
   a_gate_oneshot: assert property ((soft_trig && !os_en) |=> os_state == OS_IDLE)
      else $error("one-shot armed outside its modes");
   a_first_match_rise: assert property ((os_en && os_state == OS_WAIT && m1 && !os_trig)
      |=> s_pulse_rise)
      else $error("first match did not start pulse");
   a_second_match_end: assert property ((os_en && os_state == OS_PULSE && m2 && !os_trig)
      |=> !out_lvl && os_state == OS_IDLE && irq.match_irq_second)
      else $error("second match did not end pulse");
   a_cap_second_irq: assert property (cap2 |=> s_cap_then_irq)
      else $error("second capture or its irq missing");
   a_opp_no_irq: assert property ((cap1 && capcmp_control_reg[CAPC_OPP]) |=> !cap1_q)
      else $error("opposite-edge capture raised irq");
   a_edge_clears: assert property ((op == OP_EDGE && valid1 && capcmp_control_reg[CAPC_C2])
      |=> count_reg == '0 && capcmp_second == $past(count_reg))
      else $error("mode 10 edge did not capture and clear");

   // ==========================================
   // further checks
   // a trigger always lands on a cleared count in the wait state,
   // whatever the pulse logic was doing before
   sequence s_armed;
      os_state == OS_WAIT && !out_lvl && count_reg == '0;
   endsequence

   sequence s_cap1_then_irq;
      capcmp_first == $past(count_reg) ##1 irq.match_irq_first;
   endsequence

   a_trig_arms: assert property (
      os_trig |=> s_armed)
      else $error("trigger did not arm one-shot");
   a_idle_stays_low: assert property (
      (os_en && os_state == OS_IDLE && !os_trig && !out_lvl) |=> !out_lvl)
      else $error("output left inactive level while idle");
   a_first_cap_irq: assert property (
      (cap1 && !capcmp_control_reg[CAPC_OPP]) |=> s_cap1_then_irq)
      else $error("first capture or its irq missing");
   a_opp_cap_store: assert property (
      (cap1 && capcmp_control_reg[CAPC_OPP]) |=> capcmp_first == $past(count_reg))
      else $error("opposite-edge capture not stored");
   a_free_counts: assert property (
      (op == OP_FREE && !clr) |=> count_reg == $past(count_reg) + 1'b1)
      else $error("free-running count did not advance");
   a_ovf_soft_clear: assert property (
      (wr_ok && avs_byteenable[0] && avs_address == ADR_MODE && !avs_writedata[MODE_OVF] && !ovf_evt)
      |=> !mode_control_reg[MODE_OVF])
      else $error("overflow flag not cleared by write");
   a_bus_one_wait: assert property (
      acc |=> !avs_waitrequest)
      else $error("bus access held longer than one wait");
endmodule : ops_timer

// >>> verification/ops_src.sv
`timescale 1ns/1ps
// ==========================================
// trigger and measured pulse source
module ops_src (
   // clock
   input  wire logic          clock,
   // pins
   output ops_pkg::ops_trig_t trig
);
   import ops_pkg::*;
   // both inputs rest low unless a task moves them, so soft triggers see no stray edge
   initial trig = '0;
   // levels move only on a rising edge and are held for cyc clocks
   // callers keep cyc above two so the capture sees a settled count
   task automatic drive(input logic sel, input logic lvl, input int cyc);
      if (sel) trig.trig_in_second <= lvl;
      else trig.trig_in_first <= lvl;
      repeat (cyc) @(posedge clock);
   endtask : drive
endmodule : ops_src

// >>> verification/oneshot_and_pulse_width_timer_test.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module oneshot_and_pulse_width_timer_test;
   import ops_pkg::*;
   localparam int M = 5;
   localparam int N = 9;
   logic        clock;
   logic        nrst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   ops_trig_t   trig;
   logic        timer_out_pin;
   ops_irq_t    irq;
   int          miscompares;
   int          checks;
   int          c1;
   int          c2;
   int          hi;
   logic [31:0] ra;
   logic [31:0] rb;
   logic [7:0]  d;
   // counter narrowed to 8 bits so an overflow comes within a few hundred clocks
   ops_timer #(.CNT_W(8)) dut_u (.clock(clock), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .trig(trig), .timer_out_pin(timer_out_pin), .irq(irq));
   ops_src src_u (.clock(clock), .trig(trig));
   always #25 clock = ~clock;
   // outputs are sampled at the falling edge, where they are settled
   always @(negedge clock) begin
      if (irq.match_irq_first === 1'b1) c1++;
      if (irq.match_irq_second === 1'b1) c2++;
      if (timer_out_pin === 1'b1) hi++;
   end
   // ==========================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      // waitrequest and read data are sampled at the rising edge itself
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      check(n < 20, 32'h1);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'b1, a, v, x);
   endtask : wr
   // restart the count from zero, let it pass both compares, then clear the tallies
   task automatic os_arm();
      wr(ADR_MODE, 32'h00000000);
      wr(ADR_MODE, 32'h00000004);
      repeat (20) @(posedge clock);
      c1 = 0;
      c2 = 0;
      hi = 0;
   endtask : os_arm
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // ==========================================
   // scenarios
   task automatic t_reset();
      logic [4:0] adr [8];
      adr = '{ADR_MODE, ADR_CAPC, ADR_OUTC, ADR_EDGE, ADR_COUNT, ADR_CCF, ADR_CCS, 5'h1C};
      wr(5'h1C, 32'hFFFFFFFF);
      foreach (adr[i]) begin
         bus(1'b0, adr[i], 32'h0, ra);
         check(ra, 32'h00000000);
      end
   endtask : t_reset
   task automatic t_count();
      wr(ADR_MODE, 32'h00000004);
      bus(1'b0, ADR_MODE, 32'h0, ra);
      check(ra, 32'h00000004);
      bus(1'b0, ADR_COUNT, 32'h0, ra);
      bus(1'b0, ADR_COUNT, 32'h0, rb);
      check(rb - ra, 32'h00000003);
      repeat (260) @(posedge clock);
      bus(1'b0, ADR_MODE, 32'h0, ra);
      check(ra, 32'h00000005);
      wr(ADR_MODE, 32'h00000004);
      bus(1'b0, ADR_MODE, 32'h0, ra);
      check(ra, 32'h00000004);
      wr(ADR_MODE, 32'h00000000);
      bus(1'b0, ADR_COUNT, 32'h0, ra);
      repeat (20) @(posedge clock);
      bus(1'b0, ADR_COUNT, 32'h0, rb);
      check(ra, 32'h00000000);
      check(rb, 32'h00000000);
   endtask : t_count
   task automatic t_oneshot();
      int n;
      wr(ADR_CAPC, 32'h00000000);
      wr(ADR_EDGE, 32'h00000000);
      wr(ADR_CCF, M);
      wr(ADR_CCS, N);
      os_arm();
      wr(ADR_OUTC, 32'h00000041);
      repeat (300) @(posedge clock);
      check(hi, 0);
      wr(ADR_OUTC, 32'h00000021);
      repeat (300) @(posedge clock);
      check(hi, 0);
      os_arm();
      n = 0;
      wr(ADR_OUTC, 32'h00000061);
      do begin
         @(negedge clock);
         n++;
      end while (timer_out_pin !== 1'b1 && n < 50);
      // the write lands one clock before the count clears; the negedge tally adds one more
      check(n, M + 3);
      repeat (100) @(posedge clock);
      check(hi, N - M);
      check(c1, 1);
      check(c2, 1);
      repeat (300) @(posedge clock);
      check(hi, N - M);
      os_arm();
      src_u.drive(1'b0, 1'b1, 20);
      // next trigger only after the previous pulse has long finished
      src_u.drive(1'b0, 1'b0, 100);
      check(hi, N - M);
      check(c1, 1);
      check(c2, 1);
   endtask : t_oneshot
   task automatic t_cap_one();
      wr(ADR_OUTC, 32'h00000000);
      wr(ADR_CAPC, 32'h00000007);
      wr(ADR_EDGE, 32'h00000001);
      os_arm();
      src_u.drive(1'b0, 1'b1, 12);
      src_u.drive(1'b0, 1'b0, 20);
      bus(1'b0, ADR_CCF, 32'h0, ra);
      bus(1'b0, ADR_CCS, 32'h0, rb);
      d = ra[7:0] - rb[7:0];
      check(d, 12);
      check(c2, 1);
      check(c1, 0);
   endtask : t_cap_one
   task automatic t_cap_two();
      wr(ADR_CAPC, 32'h00000005);
      wr(ADR_EDGE, 32'h0000000F);
      os_arm();
      src_u.drive(1'b0, 1'b1, 9);
      src_u.drive(1'b1, 1'b1, 20);
      bus(1'b0, ADR_CCF, 32'h0, ra);
      bus(1'b0, ADR_CCS, 32'h0, rb);
      d = ra[7:0] - rb[7:0];
      check(d, 9);
      check(c1, 1);
      check(c2, 1);
   endtask : t_cap_two
   task automatic t_cap_edge();
      wr(ADR_MODE, 32'h00000000);
      wr(ADR_CAPC, 32'h00000007);
      wr(ADR_EDGE, 32'h00000001);
      wr(ADR_MODE, 32'h00000008);
      src_u.drive(1'b1, 1'b0, 10);
      src_u.drive(1'b0, 1'b0, 10);
      src_u.drive(1'b0, 1'b1, 10);
      src_u.drive(1'b0, 1'b0, 14);
      src_u.drive(1'b0, 1'b1, 20);
      bus(1'b0, ADR_CCF, 32'h0, ra);
      bus(1'b0, ADR_CCS, 32'h0, rb);
      d = rb[7:0] - ra[7:0];
      check(d, 14);
      check((rb[7:0] == 8'h18) || (rb[7:0] == 8'h17), 32'h1);
      // period longer than the 8-bit count: software adds one wrap per overflow
      src_u.drive(1'b0, 1'b0, 10);
      wr(ADR_MODE, 32'h00000008);
      src_u.drive(1'b0, 1'b1, 150);
      src_u.drive(1'b0, 1'b0, 150);
      src_u.drive(1'b0, 1'b1, 20);
      bus(1'b0, ADR_MODE, 32'h0, ra);
      bus(1'b0, ADR_CCS, 32'h0, rb);
      check(ra[0] * 32'h00000100 + rb[7:0], 32'h0000012B);
      wr(ADR_MODE, 32'h00000008);
      bus(1'b0, ADR_MODE, 32'h0, ra);
      check(ra, 32'h00000008);
   endtask : t_cap_edge
   // ==========================================
   // main sequence and watchdog
   initial begin
      clock          = 1'b0;
      nrst           = 1'b0;
      avs_address    = 5'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h00000000;
      avs_byteenable = 4'hF;
      miscompares    = 0;
      checks         = 0;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_count();
      t_oneshot();
      t_cap_one();
      t_cap_two();
      t_cap_edge();
      report_and_stop();
   end
   initial begin
      #500000;
      miscompares++;
      report_and_stop();
   end
endmodule : oneshot_and_pulse_width_timer_test
